// ===== core/adc_filter_defines.svh
// Purpose: Offsets, field positions, reset values of the ADC result filter
// Assumes: 16-bit registers on a plain strobe port
// Notes:   Included directly by the filter and the scaler, not through the package file
`ifndef ADC_FILTER_DEFINES_SVH
`define ADC_FILTER_DEFINES_SVH

`define ADDR_W              4
`define OFF_FILTER_CONTROL  4'h0
`define OFF_FILTER_RESULT   4'h1
`define OFF_IRQ_STATUS      4'h2
`define OFF_IRQ_MASK        4'h3
`define RST_FILTER_CONTROL  16'h0000
`define BIT_FILTER_ON       15
`define BIT_MODE_HI         14
`define BIT_MODE_LO         13
`define BIT_RATIO_HI        12
`define BIT_RATIO_LO        10
`define BIT_IRQ_ON          9
`define BIT_READY           8
`define BIT_CHAN_HI         4
`define BIT_CHAN_LO         0
`define CTRL_WR_MASK        16'hFE1F
`define MODE_AVERAGE        2'h3
`define MODE_OVERSAMPLE     2'h0

`endif

// ===== core/adc_filter_pkg.sv
// Purpose: Types shared by the ADC result filter
// Assumes: Constants live in adc_filter_defines.svh
// Notes:   Conversion results travel as one struct
package adc_filter_pkg;

    typedef struct packed
    {
        logic        valid;
        logic [4:0]  channel;
        logic [11:0] data;
    } conv_result_s;

    typedef enum logic [1:0]
    {
        FILT_IDLE,
        FILT_ACCUM,
        FILT_FINISH
    } filt_state_e;

endpackage

// ===== core/adc_oversampling_filter.sv
// Purpose: ADC result filter, oversampling or averaging one channel
// Assumes: Conversion results arrive on the system clock domain
// Notes:   Registers on a plain strobe port, read data one cycle later
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

`include "adc_filter_defines.svh"

// How it works
// - The filter runs only while filter_on is set, and clearing it clears the ready flag.
// - Mode code 11 selects averaging and code 00 oversampling; 01 and 10 are reserved.
// - Oversampling output is 12.1 for 2x/4x, 12.2 for 8x/16x, 12.3 for 32x/64x, 12.4 for 128x/256x.
// - In averaging the ratio codes 111..001 give 256 down to 4 samples and a 12-bit result.
// - With irq_on and irq_mask both set a ready result raises the common ADC interrupt, otherwise none.
// - The read-only ready flag sets on new data and clears when the result is read.
module adc_oversampling_filter
    import adc_filter_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire conv_result_s         conv_in,
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [15:0]          reg_rdata,
    output logic                      adc_irq
);

    // Sample count for a mode and ratio code
    function automatic logic [8:0] ratio_count(input logic [1:0] mode, input logic [2:0] ratio);
        logic [8:0] n;
        n = 9'h004;
        if (mode == `MODE_AVERAGE)
        begin
            case (ratio)
                3'h7:    n = 9'h100;
                3'h6:    n = 9'h080;
                3'h5:    n = 9'h040;
                3'h4:    n = 9'h020;
                3'h3:    n = 9'h010;
                3'h2:    n = 9'h008;
                default: n = 9'h004;
            endcase
        end
        else
        begin
            case (ratio)
                3'h7:    n = 9'h080;
                3'h6:    n = 9'h020;
                3'h5:    n = 9'h008;
                3'h4:    n = 9'h002;
                3'h3:    n = 9'h100;
                3'h2:    n = 9'h040;
                3'h1:    n = 9'h010;
                default: n = 9'h004;
            endcase
        end
        return n;
    endfunction

    // Registers and filter state
    logic [15:0]   control;
    logic          ready;
    logic [15:0]   filter_result_reg;
    logic          irq_status;
    logic          irq_mask;
    logic [19:0]   acc;
    logic [8:0]    count;
    filt_state_e   state;

    logic [15:0]   next_control;
    logic          next_ready;
    logic [15:0]   next_filter_result_reg;
    logic          next_irq_status;
    logic          next_irq_mask;
    logic [19:0]   next_acc;
    logic [8:0]    next_count;
    filt_state_e   next_state;
    logic [15:0]   next_reg_rdata;
    logic          next_adc_irq;

    logic          filter_on;
    logic [1:0]    mode;
    logic [2:0]    ratio_sel;
    logic          irq_on;
    logic [4:0]    filter_channel_sel;
    logic          mode_legal;
    logic          take;
    logic [15:0]   scaled;
    logic          result_event;
    logic [19:0]   acc_sum;

    assign filter_on          = control[`BIT_FILTER_ON];
    assign mode               = control[`BIT_MODE_HI:`BIT_MODE_LO];
    assign ratio_sel          = control[`BIT_RATIO_HI:`BIT_RATIO_LO];
    assign irq_on             = control[`BIT_IRQ_ON];
    assign filter_channel_sel = control[`BIT_CHAN_HI:`BIT_CHAN_LO];
    assign mode_legal         = (mode == `MODE_AVERAGE) || (mode == `MODE_OVERSAMPLE);
    assign take               = conv_in.valid && (conv_in.channel == filter_channel_sel);
    // Sum with the incoming sample, kept apart from next_acc so the scaler is no loop
    assign acc_sum            = acc + {8'h00, conv_in.data};

    filter_scaler u_scaler
    (
        .sum    (acc_sum),
        .mode   (mode),
        .ratio  (ratio_sel),
        .result (scaled)
    );

    // Filter datapath
    always_comb
    begin
        next_state             = state;
        next_acc               = acc;
        next_count             = count;
        next_filter_result_reg = filter_result_reg;
        result_event           = 1'b0;
        if (!filter_on || !mode_legal)
        begin
            next_state = FILT_IDLE;
            next_acc   = 20'h00000;
            next_count = 9'h000;
        end
        else
        begin
            case (state)
                FILT_IDLE:
                begin
                    next_acc   = 20'h00000;
                    next_count = 9'h000;
                    next_state = FILT_ACCUM;
                end
                FILT_ACCUM:
                begin
                    if (take)
                    begin
                        next_acc   = acc_sum;
                        next_count = count + 9'h001;
                        if (next_count == ratio_count(mode, ratio_sel))
                        begin
                            next_filter_result_reg = scaled;
                            result_event           = 1'b1;
                            next_state             = FILT_FINISH;
                        end
                    end
                end
                default:
                begin
                    next_acc   = 20'h00000;
                    next_count = 9'h000;
                    next_state = FILT_ACCUM;
                end
            endcase
        end
    end

    // Register port
    always_comb
    begin
        next_control    = control;
        next_irq_mask   = irq_mask;
        next_irq_status = irq_status;
        next_ready      = ready;
        next_reg_rdata  = 16'h0000;
        if (reg_wr)
        begin
            if (reg_addr == `OFF_FILTER_CONTROL)
            begin
                next_control = reg_wdata & `CTRL_WR_MASK;
            end
            else if (reg_addr == `OFF_IRQ_STATUS)
            begin
                if (reg_wdata[0])
                begin
                    next_irq_status = 1'b0;
                end
            end
            else if (reg_addr == `OFF_IRQ_MASK)
            begin
                next_irq_mask = reg_wdata[0];
            end
        end
        if (reg_rd)
        begin
            if (reg_addr == `OFF_FILTER_CONTROL)
            begin
                next_reg_rdata = control | {7'h00, ready, 8'h00};
            end
            else if (reg_addr == `OFF_FILTER_RESULT)
            begin
                next_reg_rdata = filter_result_reg;
                next_ready     = 1'b0;
            end
            else if (reg_addr == `OFF_IRQ_STATUS)
            begin
                next_reg_rdata = {15'h0000, irq_status};
            end
            else if (reg_addr == `OFF_IRQ_MASK)
            begin
                next_reg_rdata = {15'h0000, irq_mask};
            end
        end
        // New result wins over a clearing result read or status write, not over a control write clearing filter_on
        if (result_event)
        begin
            next_ready = 1'b1;
            if (irq_on)
            begin
                next_irq_status = 1'b1;
            end
        end
        if (!next_control[`BIT_FILTER_ON])
        begin
            next_ready = 1'b0;
        end
        next_adc_irq = next_irq_status && next_irq_mask && next_control[`BIT_IRQ_ON];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            control           <= `RST_FILTER_CONTROL;
            ready             <= 1'b0;
            filter_result_reg <= 16'h0000;
            irq_status        <= 1'b0;
            irq_mask          <= 1'b0;
            acc               <= 20'h00000;
            count             <= 9'h000;
            state             <= FILT_IDLE;
            reg_rdata         <= 16'h0000;
            adc_irq           <= 1'b0;
        end
        else if (clk_en)
        begin
            control           <= next_control;
            ready             <= next_ready;
            filter_result_reg <= next_filter_result_reg;
            irq_status        <= next_irq_status;
            irq_mask          <= next_irq_mask;
            acc               <= next_acc;
            count             <= next_count;
            state             <= next_state;
            reg_rdata         <= next_reg_rdata;
            adc_irq           <= next_adc_irq;
        end
    end

endmodule
`default_nettype wire

// ===== core/filter_scaler.sv
// Purpose: Turns an accumulated sum into the filter result word
// Assumes: Sum of up to 256 twelve-bit samples
// Notes:   Pure combinational shifter
`timescale 1ns/1ns
`default_nettype none

`include "adc_filter_defines.svh"

module filter_scaler
(
    input  wire logic [19:0] sum,
    input  wire logic [1:0]  mode,
    input  wire logic [2:0]  ratio,
    output logic      [15:0] result
);
    logic [19:0] shifted;

    always_comb
    begin
        shifted = 20'h00000;
        if (mode == `MODE_AVERAGE)
        begin
            // Divide by ratio for a 12-bit mean
            case (ratio)
                3'h7:    shifted = sum >> 8;
                3'h6:    shifted = sum >> 7;
                3'h5:    shifted = sum >> 6;
                3'h4:    shifted = sum >> 5;
                3'h3:    shifted = sum >> 4;
                3'h2:    shifted = sum >> 3;
                default: shifted = sum >> 2;
            endcase
        end
        else
        begin
            // Mean with one to four fraction bits: 12.1 to 12.4
            case (ratio)
                3'h4:       shifted = sum;
                3'h0, 3'h5: shifted = sum >> 1;
                3'h1, 3'h6: shifted = sum >> 2;
                3'h2, 3'h7: shifted = sum >> 3;
                default:    shifted = sum >> 4;
            endcase
        end
        result = shifted[15:0];
    end

endmodule
`default_nettype wire

// ===== testbench/adc_core_model.sv
// Purpose: Conversion core feeding results to the filter
// Assumes: Results on the system clock, one per gap+1 cycles
// Notes:   Idle cycles carry a toggling pattern, not stale data
`timescale 1ns/1ns
`default_nettype none

module adc_core_model
    import adc_filter_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         go,
    input  wire logic [4:0]   chan,
    input  wire logic [11:0]  value,
    input  wire logic [3:0]   gap,
    output var  conv_result_s conv_out
);
    logic [3:0] cnt;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cnt <= 4'h0;
            conv_out <= '0;
        end
        else if (go && cnt >= gap)
        begin
            cnt <= 4'h0;
            conv_out <= {1'b1, chan, value};
        end
        else
        begin
            cnt <= cnt + 4'h1;
            conv_out <= {1'b0, ~conv_out.channel, ~conv_out.data};
        end
    end
endmodule

`default_nettype wire

// ===== testbench/adc_filter_monitor.sv
// Purpose: Port-level checks of the ADC result filter
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into the filter's top module
`timescale 1ns/1ns
`default_nettype none

module adc_filter_monitor
    import adc_filter_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         reset_n,
    input wire logic         clk_en,
    input wire conv_result_s conv_in,
    input wire logic [3:0]   reg_addr,
    input wire logic [15:0]  reg_wdata,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [15:0]  reg_rdata,
    input wire logic         adc_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    logic rd_ctl;
    logic rd_res;
    logic wr_ctl;
    assign rd_ctl = clk_en && reg_rd && reg_addr == 4'h0;
    assign rd_res = clk_en && reg_rd && reg_addr == 4'h1;
    assign wr_ctl = clk_en && reg_wr && reg_addr == 4'h0;

    property p_reset; disable iff (1'b0) !reset_n && clk_en |=> !adc_irq && reg_rdata == 16'h0000; endproperty
    property p_ready_on; rd_ctl |=> !reg_rdata[8] || reg_rdata[15]; endproperty
    property p_off; wr_ctl && !reg_wdata[15] ##1 !reg_wr ##1 rd_ctl |=> !reg_rdata[8]; endproperty
    property p_irq_en; adc_irq && rd_ctl |=> reg_rdata[9]; endproperty
    property p_clr; rd_res && !conv_in.valid ##1 !conv_in.valid ##1 rd_ctl |=> !reg_rdata[8]; endproperty
    property p_back;
        wr_ctl ##1 !reg_wr ##1 rd_ctl |=>
            {reg_rdata[15:9], reg_rdata[4:0]} == {$past(reg_wdata[15:9], 3), $past(reg_wdata[4:0], 3)};
    endproperty
    property p_ack; clk_en && reg_wr && reg_addr == 4'h2 && reg_wdata[0] && !conv_in.valid |=> !adc_irq; endproperty
    property p_mask; clk_en && reg_wr && reg_addr == 4'h3 && !reg_wdata[0] |=> !adc_irq; endproperty

    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    a_ready_on: assert property (p_ready_on) else $error("ready set while filter off");
    a_off: assert property (p_off) else $error("ready survived filter disable");
    a_irq_en: assert property (p_irq_en) else $error("interrupt without irq_on");
    a_clr: assert property (p_clr) else $error("ready not cleared by result read");
    a_back: assert property (p_back) else $error("control readback mismatch");
    a_ack: assert property (p_ack) else $error("interrupt not cleared by status write");
    a_mask: assert property (p_mask) else $error("masked interrupt still high");

    c_res: cover property (rd_res);
    c_irq: cover property (adc_irq);
    c_back: cover property (wr_ctl ##1 !reg_wr ##1 rd_ctl);
endmodule

bind adc_oversampling_filter adc_filter_monitor mon_u (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .conv_in(conv_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_irq(adc_irq));

`default_nettype wire

// ===== testbench/tb_adc_oversampling_filter.sv
// Purpose: Self-checking bench of the ADC result filter
// Assumes: clk_en high except for one frozen write in t_regs, core model feeds channel results
// Notes:   Tasks start and end on a rising edge
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_adc_oversampling_filter
    import adc_filter_pkg::*;
;
    logic         clk_sys;
    logic         reset_n;
    logic         clk_en;
    logic         reg_wr;
    logic         reg_rd;
    logic         go;
    logic         adc_irq;
    logic [3:0]   reg_addr;
    logic [3:0]   gap;
    logic [4:0]   chan;
    logic [11:0]  value;
    logic [15:0]  reg_wdata;
    logic [15:0]  reg_rdata;
    logic [15:0]  d;
    conv_result_s conv_in;
    int           failures;
    int           n_checks;
    int           c;

    adc_oversampling_filter dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .conv_in(conv_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .adc_irq(adc_irq));
    adc_core_model core_u (.clk_sys(clk_sys), .reset_n(reset_n), .go(go), .chan(chan), .value(value),
        .gap(gap), .conv_out(conv_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
    endtask

    // Restart filter, feed results, wait for ready, stop the core
    task automatic run(input logic [15:0] ctl, input logic [11:0] v, input logic [3:0] g);
        int k;
        wr(4'h0, 16'h0000);
        wr(4'h0, ctl);
        value <= v;
        chan <= ctl[4:0];
        gap <= g;
        go <= 1'b1;
        d = 16'h0000;
        for (k = 0; k < 3000 && d[8] !== 1'b1; k++)
            rd(4'h0, d);
        if (d[8] !== 1'b1)
        begin
            failures++;
            print_verdict();
        end
        go <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic t_regs();
        for (c = 0; c < 6; c++)
        begin
            rd(4'(c), d);
            `CHK(d, 16'h0000)
        end
        // Write while frozen must not land
        clk_en <= 1'b0;
        wr(4'h0, 16'hFFFF);
        clk_en <= 1'b1;
        rd(4'h0, d);
        `CHK(d, 16'h0000)
        wr(4'h0, 16'hFFFF);
        rd(4'h0, d);
        `CHK(d, 16'hFE1F)
        wr(4'h1, 16'h1234);
        rd(4'h1, d);
        `CHK(d, 16'h0000)
        $display("t_regs done");
    endtask

    task automatic t_over();
        int n [8] = '{4, 16, 64, 256, 2, 8, 32, 128};
        int s;
        for (c = 0; c < 8; c++)
        begin
            run({1'b1, 2'b00, 3'(c), 5'h00, 5'h03}, 12'hABC, 4'h0);
            s = (n[c] <= 4) ? 1 : (n[c] <= 16) ? 2 : (n[c] <= 64) ? 3 : 4;
            rd(4'h1, d);
            // Equal samples: the mean with s fraction bits
            `CHK(d, 16'(20'hABC << s))
            rd(4'h0, d);
            `CHK(d[8], 1'b0)
        end
        $display("t_over done");
    endtask

    task automatic t_avg();
        for (c = 1; c < 8; c++)
        begin
            run({1'b1, 2'b11, 3'(c), 5'h00, 5'h03}, 12'h5A3, 4'h3);
            rd(4'h1, d);
            `CHK(d, 16'h05A3)
        end
        $display("t_avg done");
    endtask

    task automatic t_refuse();
        logic [1:0] m [3] = '{2'b01, 2'b10, 2'b00};
        for (c = 0; c < 3; c++)
        begin
            wr(4'h0, 16'h0000);
            wr(4'h0, {1'b1, m[c], 3'h1, 5'h00, 5'h03});
            value <= 12'h111;
            chan <= (c == 2) ? 5'h04 : 5'h03;
            gap <= 4'h0;
            go <= 1'b1;
            repeat (40) @(posedge clk_sys);
            go <= 1'b0;
            rd(4'h0, d);
            `CHK(d[8], 1'b0)
            rd(4'h1, d);
            `CHK(d, 16'h05A3)
        end
        $display("t_refuse done");
    endtask

    task automatic t_irq();
        wr(4'h3, 16'h0001);
        run(16'h8203, 12'h010, 4'h1);
        `CHK(adc_irq, 1'b1)
        rd(4'h2, d);
        `CHK(d[0], 1'b1)
        wr(4'h3, 16'h0000);
        `CHK(adc_irq, 1'b0)
        wr(4'h3, 16'h0001);
        `CHK(adc_irq, 1'b1)
        wr(4'h2, 16'h0001);
        `CHK(adc_irq, 1'b0)
        run(16'h8003, 12'h020, 4'h0);
        rd(4'h2, d);
        `CHK({adc_irq, d[0]}, 2'b00)
        wr(4'h0, 16'h0003);
        rd(4'h0, d);
        `CHK(d[8], 1'b0)
        $display("t_irq done");
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        {reset_n, reg_wr, reg_rd, go, reg_addr, gap, reg_wdata, chan, value} = '0;
        clk_en = 1'b1;
        failures = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_over();
        t_avg();
        t_refuse();
        t_irq();
        print_verdict();
    end
endmodule

`default_nettype wire
